// >>> hw/sinc_seq_pkg.sv
/*
  Constants, types and helper functions shared by the sinc decimation
  filter sequencer and its testbench; the result FIFO does not use them.
  Assumes a 20 MHz system clock from which the master clock ticks are derived.
*/
package sinc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clocking
  localparam int CLK_HZ = 20000000;
  localparam int MCLK_FULL_HZ = 614400;
  localparam int MCLK_MID_HZ = 153600;
  localparam int MCLK_LOW_HZ = 76800;
  localparam int PHASE_UNIT_HZ = 100;
  localparam int PHASE_W = 18;
  localparam logic [PHASE_W:0] PHASE_MOD = (PHASE_W+1)'(CLK_HZ / PHASE_UNIT_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // filter timing
  localparam int DIV_W = 11;
  localparam logic [DIV_W-1:0] DIV_MIN = 11'h001;
  localparam int DEC_FACTOR = 32;
  localparam int DEC_W = 16;
  localparam int DEAD_W = 7;
  localparam logic [DEAD_W-1:0] DEAD_FIRST = 7'h5f;     // 95 master clocks
  localparam logic [DEAD_W-1:0] DEAD_FIRST_FS1 = 7'h3d; // 61 master clocks
  localparam logic [DEAD_W-1:0] DEAD_SEQ = 7'h1e;       // 30 master clocks
  localparam int SINC3_ORDER = 3;
  localparam int SINC4_ORDER = 4;
  localparam int AVG_W = 5;
  localparam logic [AVG_W-1:0] AVG_FULL_MID = 5'h10;
  localparam logic [AVG_W-1:0] AVG_LOW = 5'h08;
  localparam int NOTCH_BASE_HZ = 50;
  localparam int NOTCH_EXTRA_HZ = 60;
  localparam int CHAN_N = 16;
  localparam int CHAN_W = 4;
  localparam int ACC_W = 84;
  localparam int TICKS_W = 21;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {PWR_LOW = 2'h0, PWR_MID = 2'h1, PWR_FULL = 2'h2} power_mode_t;
  typedef enum logic {FILT_SINC3 = 1'b0, FILT_FAST = 1'b1} filter_type_t;

  typedef struct packed {
    power_mode_t power;
    filter_type_t ftype;
    logic zero_latency;
    logic extra_sixty_hz_notch;
    logic [DIV_W-1:0] output_rate_divider;
  } filter_cfg_t;

  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    logic first_after_change;
    logic [ACC_W-1:0] value;
  } result_t;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic int mclk_hz(input power_mode_t p);
    case (p)
      PWR_FULL: return MCLK_FULL_HZ;
      PWR_MID: return MCLK_MID_HZ;
      default: return MCLK_LOW_HZ;
    endcase
  endfunction

  function automatic logic [PHASE_W-1:0] mclk_inc(input power_mode_t p);
    return PHASE_W'(mclk_hz(p) / PHASE_UNIT_HZ);
  endfunction

  function automatic logic [AVG_W-1:0] avg_count(input power_mode_t p);
    return (p == PWR_LOW) ? AVG_LOW : AVG_FULL_MID;
  endfunction

  function automatic logic [DIV_W-1:0] fs_at_base_notch(input power_mode_t p);
    return DIV_W'(mclk_hz(p) / (DEC_FACTOR * NOTCH_BASE_HZ));
  endfunction

  function automatic int rej_delay(input power_mode_t p);
    return mclk_hz(p) / NOTCH_EXTRA_HZ;
  endfunction

  function automatic logic [DEC_W-1:0] dec_len(input logic [DIV_W-1:0] d);
    return DEC_W'(int'(d) * DEC_FACTOR);
  endfunction

endpackage

// >>> hw/result_fifo.sv
/*
  Small synchronous FIFO for conversion results, valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module result_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,              // system clock
  input wire logic reset_n_i,          // synchronous reset, active low
  input wire logic in_valid_i,         // writer offers a word
  output logic in_ready_o,             // fifo not full
  input wire logic [WIDTH-1:0] in_data_i, // word to store
  output logic out_valid_o,            // fifo not empty
  input wire logic out_ready_i,        // reader takes the word
  output logic [WIDTH-1:0] out_data_o  // oldest word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("result_fifo depth must be a power of two, at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready_o = (wr_r ^ rd_r) != {1'b1, {AW{1'b0}}};
  assign out_valid_o = wr_r != rd_r;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_data_o = mem_r[rd_r[AW-1:0]];

  // storage
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_r <= '0;
      rd_r <= '0;
    end else begin
      if (push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end

endmodule // result_fifo

// >>> hw/sinc_decimation_filter_sequencer.sv
/*
  Sinc3 / fast-settling (sinc4 + averaging) decimation filter with channel
  sequencer and dead-time timing, results buffered in a 4-word FIFO.
  Assumes configuration inputs from logic on clk_i and a modulator bit pin.
*/
`timescale 1ns/1ns
module sinc_decimation_filter_sequencer #(
  parameter int CHAN_N = sinc_seq_pkg::CHAN_N,
  parameter int FIFO_DEPTH = 4,
  parameter int REJ_DEPTH = 10240
) (
  input wire logic clk_i,                            // 20 MHz system clock
  input wire logic reset_n_i,                        // synchronous reset, active low
  input wire sinc_seq_pkg::filter_cfg_t cfg_i,       // filter settings
  input wire logic [CHAN_N-1:0] channel_enable_i,    // enabled channels
  input wire logic mod_bit_i,                        // modulator bitstream pin
  output logic mclk_tick_o,                          // master clock tick
  output logic modulator_reset_o,                    // modulator reset pulse
  output logic [sinc_seq_pkg::CHAN_W-1:0] active_channel_o, // channel converting
  output logic conv_done_o,                          // conversion complete pulse
  output logic [sinc_seq_pkg::CHAN_W-1:0] done_channel_o,   // channel of that result
  output logic result_valid_o,                       // fifo holds a result
  input wire logic result_ready_i,                   // reader takes a result
  output sinc_seq_pkg::result_t result_o             // oldest result
);

  localparam int CW = sinc_seq_pkg::CHAN_W;
  localparam int AW = sinc_seq_pkg::ACC_W;
  localparam int RW = $clog2(REJ_DEPTH + 1);
  localparam int TW = sinc_seq_pkg::TICKS_W;

  generate
    if (CHAN_N < 1 || CHAN_N > (1 << CW)) begin : g_bad_chan
      $error("channel count does not fit the channel field");
    end
    if (REJ_DEPTH < sinc_seq_pkg::MCLK_FULL_HZ / sinc_seq_pkg::NOTCH_EXTRA_HZ) begin : g_bad_rej
      $error("notch delay line too short for full power");
    end
  endgenerate

  typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_DEAD = 2'h1, ST_RUN = 2'h3} seq_state_t;

  function automatic logic [CW-1:0] first_chan(input logic [CHAN_N-1:0] m);
    logic [CW-1:0] n;
    n = '0;
    for (int k = CHAN_N - 1; k >= 0; k--) begin
      if (m[k]) n = CW'(k);
    end
    return n;
  endfunction

  function automatic logic [CW-1:0] next_chan(input logic [CHAN_N-1:0] m, input logic [CW-1:0] c);
    logic [CW-1:0] n;
    int k;
    n = c;
    for (int i = CHAN_N - 1; i >= 1; i--) begin
      k = (int'(c) + i) % CHAN_N;
      if (m[k]) n = CW'(k);
    end
    return n;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // configuration capture and change detection
  sinc_seq_pkg::filter_cfg_t cfg_r;
  logic [CHAN_N-1:0] mask_r;
  logic cfg_chg;
  logic multi;
  logic [sinc_seq_pkg::DIV_W-1:0] div;
  logic [sinc_seq_pkg::DEC_W-1:0] dlen;
  logic [sinc_seq_pkg::AVG_W-1:0] avg_n;
  logic fast;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cfg_r <= '0;
      mask_r <= '0;
    end else begin
      cfg_r <= cfg_i;
      mask_r <= channel_enable_i;
    end
  end

  assign cfg_chg = (cfg_i != cfg_r) || (channel_enable_i != mask_r);
  assign multi = (mask_r & (mask_r - 1'b1)) != '0;
  assign div = (cfg_r.output_rate_divider == '0) ? sinc_seq_pkg::DIV_MIN : cfg_r.output_rate_divider;
  assign dlen = sinc_seq_pkg::dec_len(div);
  assign avg_n = sinc_seq_pkg::avg_count(cfg_r.power);
  assign fast = cfg_r.ftype == sinc_seq_pkg::FILT_FAST;

  ////////////////////////////////////////////////////////////////////////////
  // master clock ticks from a fractional phase accumulator
  logic [sinc_seq_pkg::PHASE_W-1:0] phase_r;
  logic [sinc_seq_pkg::PHASE_W:0] phase_sum;
  logic tick_r;
  logic stall;
  logic tick_en;

  assign phase_sum = {1'b0, phase_r} + {1'b0, sinc_seq_pkg::mclk_inc(cfg_r.power)};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      phase_r <= '0;
      tick_r <= 1'b0;
    end else if (phase_sum >= sinc_seq_pkg::PHASE_MOD) begin
      phase_r <= sinc_seq_pkg::PHASE_W'(phase_sum - sinc_seq_pkg::PHASE_MOD);
      tick_r <= 1'b1;
    end else begin
      phase_r <= phase_sum[sinc_seq_pkg::PHASE_W-1:0];
      tick_r <= 1'b0;
    end
  end

  assign tick_en = tick_r && !stall;
  assign mclk_tick_o = tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // modulator pin synchroniser
  logic mod_s1_r;
  logic mod_s2_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mod_s1_r <= 1'b0;
      mod_s2_r <= 1'b0;
    end else begin
      mod_s1_r <= mod_bit_i;
      mod_s2_r <= mod_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  seq_state_t state_r;
  logic [CW-1:0] chan_r;
  logic [sinc_seq_pkg::DEAD_W-1:0] dead_r;
  logic [sinc_seq_pkg::DEAD_W-1:0] first_dead;
  logic start;
  logic res_set;
  logic restart;
  logic filt_clr;
  logic run_tick;
  logic modrst_r;

  // shorter first dead time only for sinc3 at the minimum divider
  assign first_dead = (!fast && div == sinc_seq_pkg::DIV_MIN) ? sinc_seq_pkg::DEAD_FIRST_FS1
                                                              : sinc_seq_pkg::DEAD_FIRST;
  assign start = (state_r == ST_IDLE) && !cfg_chg && (mask_r != '0);
  assign run_tick = tick_en && (state_r == ST_RUN);
  // single-shot conversions restart; plain sinc3 on one channel free-runs
  assign restart = res_set && (multi || fast || cfg_r.zero_latency);
  assign filt_clr = cfg_chg || (state_r == ST_IDLE) || restart;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_r <= ST_IDLE;
      chan_r <= '0;
      dead_r <= '0;
    end else if (cfg_chg) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            chan_r <= first_chan(mask_r);
            dead_r <= first_dead;
            state_r <= ST_DEAD;
          end
        end
        ST_DEAD: begin
          if (tick_en) begin
            dead_r <= dead_r - 1'b1;
            if (dead_r <= 1) begin
              state_r <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (restart && multi) begin
            chan_r <= next_chan(mask_r, chan_r);
            dead_r <= sinc_seq_pkg::DEAD_SEQ;
            state_r <= ST_DEAD;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // modulator reset on every channel switch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      modrst_r <= 1'b0;
    end else begin
      modrst_r <= start || (restart && multi && !cfg_chg);
    end
  end

  assign modulator_reset_o = modrst_r;
  assign active_channel_o = chan_r;

  ////////////////////////////////////////////////////////////////////////////
  // first-order sixty hertz notch on the bitstream
  logic ring_r [REJ_DEPTH];
  logic [RW-1:0] rptr_r;
  logic [RW-1:0] rfill_r;
  logic [RW-1:0] msum_r;
  logic [RW-1:0] rdelay;
  logic rej_on;
  logic old_bit;

  assign rdelay = RW'(sinc_seq_pkg::rej_delay(cfg_r.power));
  assign rej_on = cfg_r.extra_sixty_hz_notch && (div == sinc_seq_pkg::fs_at_base_notch(cfg_r.power));
  assign old_bit = (rfill_r == rdelay) ? ring_r[rptr_r] : 1'b0;

  always_ff @(posedge clk_i) begin
    if (run_tick) begin
      ring_r[rptr_r] <= mod_s2_r;
    end
  end

  // moving sum over one sixtieth of a second of bits
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || filt_clr) begin
      rptr_r <= '0;
      rfill_r <= '0;
      msum_r <= '0;
    end else if (run_tick) begin
      rptr_r <= (rptr_r == rdelay - 1'b1) ? '0 : rptr_r + 1'b1;
      if (rfill_r != rdelay) begin
        rfill_r <= rfill_r + 1'b1;
      end
      msum_r <= msum_r + RW'(mod_s2_r) - RW'(old_bit);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cascaded integrators, decimation, combs and averaging
  logic [AW-1:0] integ_r [sinc_seq_pkg::SINC4_ORDER];
  logic [AW-1:0] comb_r [sinc_seq_pkg::SINC4_ORDER];
  logic [AW-1:0] stage [sinc_seq_pkg::SINC4_ORDER+1];
  logic [AW-1:0] x_in;
  logic [AW-1:0] y;
  logic [AW-1:0] avg_sum_r;
  logic [sinc_seq_pkg::AVG_W-1:0] avg_cnt_r;
  logic [sinc_seq_pkg::DEC_W-1:0] dec_r;
  logic [2:0] outs_r;
  logic [2:0] fill_n;
  logic dec_last;
  logic filled;
  logic avg_done;

  assign x_in = rej_on ? AW'(msum_r) : AW'(mod_s2_r);
  assign fill_n = fast ? 3'(sinc_seq_pkg::SINC4_ORDER - 1) : 3'(sinc_seq_pkg::SINC3_ORDER - 1);
  assign dec_last = dec_r == dlen - 1'b1;
  assign filled = outs_r == fill_n;
  assign avg_done = avg_cnt_r == avg_n - 1'b1;

  // comb chain fed from the integrator of the selected order
  always_comb begin
    stage[0] = fast ? integ_r[sinc_seq_pkg::SINC4_ORDER-1] : integ_r[sinc_seq_pkg::SINC3_ORDER-1];
    for (int k = 0; k < sinc_seq_pkg::SINC4_ORDER; k++) begin
      stage[k+1] = stage[k] - comb_r[k];
    end
    y = fast ? stage[sinc_seq_pkg::SINC4_ORDER] : stage[sinc_seq_pkg::SINC3_ORDER];
  end

  // result after filter fill: each output in sinc3, after averaging in fast mode
  assign res_set = run_tick && dec_last && filled && !cfg_chg && (!fast || avg_done);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || filt_clr) begin
      for (int k = 0; k < sinc_seq_pkg::SINC4_ORDER; k++) begin
        integ_r[k] <= '0;
        comb_r[k] <= '0;
      end
      dec_r <= '0;
      outs_r <= '0;
      avg_cnt_r <= '0;
      avg_sum_r <= '0;
    end else if (run_tick) begin
      integ_r[0] <= integ_r[0] + x_in;
      for (int k = 1; k < sinc_seq_pkg::SINC4_ORDER; k++) begin
        integ_r[k] <= integ_r[k] + integ_r[k-1];
      end
      dec_r <= dec_last ? '0 : dec_r + 1'b1;
      if (dec_last) begin
        for (int k = 0; k < sinc_seq_pkg::SINC4_ORDER; k++) begin
          comb_r[k] <= stage[k];
        end
        if (!filled) begin
          outs_r <= outs_r + 1'b1;
        end else if (fast) begin
          avg_cnt_r <= avg_cnt_r + 1'b1;
          avg_sum_r <= avg_sum_r + y;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // result register, completion pulse and fifo
  sinc_seq_pkg::result_t res_r;
  logic res_valid_r;
  logic fifo_ready;
  logic first_r;
  logic done_r;
  logic [CW-1:0] done_chan_r;

  assign stall = res_valid_r && !fifo_ready;

  // marks the first result after a filter restart on a new channel
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      first_r <= 1'b0;
    end else if (start || (restart && multi)) begin
      first_r <= 1'b1;
    end else if (res_set) begin
      first_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      res_r <= '0;
      res_valid_r <= 1'b0;
      done_r <= 1'b0;
      done_chan_r <= '0;
    end else begin
      done_r <= res_set;
      if (res_set) begin
        res_valid_r <= 1'b1;
        res_r.channel <= chan_r;
        res_r.first_after_change <= first_r;
        res_r.value <= fast ? avg_sum_r + y : y;
        done_chan_r <= chan_r;
      end else if (fifo_ready) begin
        res_valid_r <= 1'b0;
      end
    end
  end

  assign conv_done_o = done_r;
  assign done_channel_o = done_chan_r;

  result_fifo #(
    .WIDTH($bits(sinc_seq_pkg::result_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(res_valid_r),
    .in_ready_o(fifo_ready),
    .in_data_i(res_r),
    .out_valid_o(result_valid_o),
    .out_ready_i(result_ready_i),
    .out_data_o(result_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic [8:0] gap_r;
  logic hold_r;
  logic [TW-1:0] conv_ticks_r;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      gap_r <= '0;
      hold_r <= 1'b0;
      conv_ticks_r <= '0;
    end else begin
      gap_r <= tick_r ? '0 : gap_r + 1'b1;
      hold_r <= (cfg_i.power == cfg_r.power) && (tick_r || hold_r);
      conv_ticks_r <= filt_clr ? '0 : (run_tick ? conv_ticks_r + 1'b1 : conv_ticks_r);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_mclk_period: assert property ((tick_r && hold_r && cfg_r.power == sinc_seq_pkg::PWR_FULL) |->
    (gap_r == 9'h01f || gap_r == 9'h020)) else $error("full power tick spacing wrong");
  a_first_dead: assert property (start |=> state_r == ST_DEAD && dead_r == $past(first_dead))
    else $error("first dead time wrong");
  a_seq_dead: assert property ((restart && multi && !cfg_chg) |=>
    state_r == ST_DEAD && dead_r == sinc_seq_pkg::DEAD_SEQ) else $error("sequencer dead time wrong");
  a_modrst_chan: assert property (!$stable(chan_r) |-> modulator_reset_o)
    else $error("channel changed without modulator reset");
  a_next_enabled: assert property ((res_set && multi) ##1 $stable(mask_r) |->
    mask_r[chan_r] && chan_r != $past(chan_r)) else $error("sequencer did not move to an enabled channel");
  a_fast_period: assert property ((res_set && fast) |-> TW'(conv_ticks_r + 1'b1) ==
    TW'((sinc_seq_pkg::SINC4_ORDER - 1 + int'(avg_n)) * int'(dlen))) else $error("fast conversion length wrong");
  a_zl_period: assert property ((res_set && !fast && cfg_r.zero_latency) |->
    TW'(conv_ticks_r + 1'b1) == TW'(sinc_seq_pkg::SINC3_ORDER * int'(dlen))) else $error("zero latency length wrong");
  a_cont_norestart: assert property ((res_set && !multi && !fast && !cfg_r.zero_latency) |=>
    state_r == ST_RUN && conv_ticks_r != '0) else $error("continuous sinc3 restarted");
  a_done_ident: assert property (res_set |=> conv_done_o && done_channel_o == $past(chan_r))
    else $error("completion pulse or channel wrong");

  c_seq_result: cover property (res_set && multi);
  c_fast_result: cover property (res_set && fast);
  c_notch_result: cover property (res_set && rej_on);
  c_stall: cover property (stall && tick_r);

endmodule // sinc_decimation_filter_sequencer

// >>> test/testbench.sv
/*
  Self-checking bench for the sinc decimation filter sequencer.
  Assumes the package and design files are compiled first, 20 MHz clock.
*/
`timescale 1ns/1ns
module testbench;
  logic clk_i;
  logic reset_n_i;
  sinc_seq_pkg::filter_cfg_t cfg_i;
  logic [15:0] mask;
  logic mod_bit_i;
  logic result_ready_i;
  logic mclk_tick_o, modulator_reset_o, conv_done_o, result_valid_o;
  logic [3:0] active_channel_o, done_channel_o;
  sinc_seq_pkg::result_t result_o;
  int error_cnt = 0;
  int tests_run = 0;

  sinc_decimation_filter_sequencer dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i),
    .channel_enable_i(mask), .mod_bit_i(mod_bit_i), .mclk_tick_o(mclk_tick_o),
    .modulator_reset_o(modulator_reset_o), .active_channel_o(active_channel_o), .conv_done_o(conv_done_o),
    .done_channel_o(done_channel_o), .result_valid_o(result_valid_o), .result_ready_i(result_ready_i),
    .result_o(result_o));

  ////////////////////////////////////////////////////////////////////////////
  // clock and a toggling modulator bit
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(negedge clk_i) mod_bit_i <= (mod_bit_i === 1'b1) ? 1'b0 : 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // compare tasks and closing
  task automatic chk_num(input int got, input int exp, input string msg);
    tests_run++;
    if (got != exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %0d exp %0d", $time, msg, got, exp);
    end
  endtask
  task automatic chk_bits(input logic [3:0] got, input logic [3:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // helpers: apply settings, wait for a result counting ticks and resets
  task automatic setcfg(input sinc_seq_pkg::power_mode_t p, input logic ft, input logic zl,
                        input logic [10:0] div, input logic [15:0] m);
    @(negedge clk_i);
    cfg_i <= '{power: p, ftype: sinc_seq_pkg::filter_type_t'(ft), zero_latency: zl,
               extra_sixty_hz_notch: 1'b0, output_rate_divider: div};
    mask <= m;
  endtask
  task automatic wait_done(output int n, output int m);
    int c;
    n = 0;
    m = 0;
    c = 0;
    do begin
      @(negedge clk_i);
      n += int'(mclk_tick_o === 1'b1);
      m += int'(modulator_reset_o === 1'b1);
      c++;
    end while (conv_done_o !== 1'b1 && c < 30000);
    if (c >= 30000) chk_num(0, 1, "no result");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_mclk(input sinc_seq_pkg::power_mode_t p, input int f);
    int c, lo;
    c = 0;
    lo = 20 * sinc_seq_pkg::CLK_HZ / f;
    setcfg(p, 1'b0, 1'b0, 11'h001, 16'h0000);
    repeat (4) @(negedge clk_i);
    while (mclk_tick_o !== 1'b1) @(negedge clk_i);
    for (int k = 0; k < 20; k++) begin
      do begin @(negedge clk_i); c++; end while (mclk_tick_o !== 1'b1 && c < 9000);
    end
    chk_num(int'(c >= lo && c <= lo + 1), 1, "tick period");
  endtask
  task automatic t_idle();
    int seen;
    seen = 0;
    repeat (2000) begin
      @(negedge clk_i);
      seen += int'(conv_done_o === 1'b1 || modulator_reset_o === 1'b1);
    end
    chk_num(seen, 0, "idle activity");
  endtask
  task automatic t_single(input logic ft, input logic zl, input logic [10:0] div, input int exp);
    int n, m;
    setcfg(sinc_seq_pkg::PWR_FULL, ft, zl, div, 16'h0004);
    wait_done(n, m);
    chk_num(m, 1, "start reset");
    wait_done(n, m);
    chk_num(n, exp, "period");
    chk_bits(done_channel_o, 4'h2, "done channel");
  endtask
  task automatic t_seq();
    int n, m;
    logic [3:0] want [3] = '{4'h1, 4'h3, 4'h1};
    setcfg(sinc_seq_pkg::PWR_FULL, 1'b0, 1'b0, 11'h001, 16'h000a);
    // let the last result of the previous scenario drain first
    repeat (3) @(negedge clk_i);
    result_ready_i <= 1'b0;
    wait_done(n, m);
    chk_bits(done_channel_o, 4'h1, "first channel");
    chk_bits(active_channel_o, 4'h3, "next channel");
    for (int k = 1; k < 3; k++) begin
      wait_done(n, m);
      chk_num(n, 30 + 3 * 32, "step period");
      chk_num(m, 1, "step reset");
      chk_bits(done_channel_o, want[k], "step channel");
    end
    for (int k = 0; k < 3; k++) begin
      chk_bits({3'h0, result_valid_o}, 4'h1, "fifo valid");
      chk_bits(result_o.channel, want[k], "fifo order");
      chk_bits({3'h0, result_o.first_after_change}, 4'h1, "new channel flag");
      chk_num(int'(result_o.value <= 84'h8000 && result_o.value != '0), 1, "sinc3 value range");
      result_ready_i <= 1'b1;
      @(negedge clk_i);
      result_ready_i <= 1'b0;
      @(negedge clk_i);
    end
    result_ready_i <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    reset_n_i = 1'b0;
    cfg_i = '0;
    mask = 16'h0000;
    mod_bit_i = 1'b0;
    result_ready_i = 1'b1;
    repeat (16) @(negedge clk_i);
    reset_n_i <= 1'b1;
    t_mclk(sinc_seq_pkg::PWR_FULL, 614400);
    t_mclk(sinc_seq_pkg::PWR_MID, 153600);
    t_mclk(sinc_seq_pkg::PWR_LOW, 76800);
    t_idle();
    t_single(1'b0, 1'b0, 11'h001, 32);
    t_single(1'b0, 1'b1, 11'h002, 3 * 32 * 2);
    t_seq();
    t_single(1'b1, 1'b0, 11'h001, (4 + 16 - 1) * 32);
    finish_test();
  end
  initial begin
    repeat (99000) @(posedge clk_i);
    error_cnt++;
    finish_test();
  end
endmodule // testbench
